// >>> design/fieldbus_serial_frame_gateway.sv
// gateway between cyclic process images and an asynchronous serial port
//
// Overview of operation
// - images hold zero to 250 bytes
// - transmit frames of 1 to 248 characters
// - receive 1 to 248 characters, idle timeout ends
// - bit rates 1200 to 115200 baud
// - formats 8N1, 8E1, 8O1, 7N2
// - toggle byte change starts a transmission
// - toggle ignored until last character sent
// - connection comes up automatically after power-on
// - red indicator off once connection runs
// - identify request blinks green indicator
// - post characters, then count and increment input toggle in one cycle
// - timeout counts from last received character
// - two-wire mode disables receiver while transmitting
// - switches sampled once after reset only
`timescale 1ns/1ns
module fieldbus_serial_frame_gateway #(
    parameter int CLK_HZ = gw_pkg::CLK_HZ_DEF,
    parameter int CYC_PER_MS = CLK_HZ / gw_pkg::MS_PER_S,
    parameter int BLINK_CYCLES = gw_pkg::BLINK_MS * CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire gw_pkg::img_wr_t out_wr,
    input wire logic [7:0] out_size,
    input wire logic [7:0] in_rd_addr,
    output logic [7:0] in_rd_data,
    input wire logic [7:0] in_size,
    input wire logic ar_up,
    input wire logic ident_flash,
    input wire logic [6:0] dip,
    input wire logic rxd,
    output logic txd,
    output logic tx_drv_en,
    output logic rx_en,
    output logic dev_online,
    output logic run_led,
    output logic err_led
);
    if (CLK_HZ / gw_pkg::MIN_BAUD >= (1 << gw_pkg::CNT_W) || CYC_PER_MS < 1 || BLINK_CYCLES < 1) begin : g_chk
        $error("gateway parameters out of range");
    end

    // ----------------------------------------------------------------
    // pin synchronisers and switch capture
    // ----------------------------------------------------------------
    logic [7:0] sync1, sync2, sync3, filt;
    logic [7:0] next_filt;
    logic [1:0] settle;
    logic [1:0] next_settle;
    logic cfg_valid, next_cfg_valid;
    gw_pkg::ser_cfg_t cfg, next_cfg;
    logic rxd_f;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_filt[i] = (sync2[i] == sync3[i]) ? sync3[i] : filt[i];
        end
        next_settle = settle;
        next_cfg = cfg;
        next_cfg_valid = cfg_valid;
        if (!cfg_valid) begin
            if (settle == 2'(gw_pkg::STRAP_SETTLE)) begin
                next_cfg = gw_pkg::ser_cfg_t'({next_filt[2:0], next_filt[4:3], next_filt[5], next_filt[6]});
                next_cfg_valid = 1'b1;
            end else begin
                next_settle = settle + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 8'hff;
            sync2 <= 8'hff;
            sync3 <= 8'hff;
            filt <= 8'hff;
            settle <= 2'h0;
            cfg <= '0;
            cfg_valid <= 1'b0;
        end else begin
            sync1 <= {rxd, dip};
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= next_filt;
            settle <= next_settle;
            cfg <= next_cfg;
            cfg_valid <= next_cfg_valid;
        end
    end

    assign rxd_f = filt[7];

    logic [gw_pkg::CNT_W-1:0] bit_cyc;
    logic [gw_pkg::TOUT_W-1:0] tout_cyc;
    assign bit_cyc = gw_pkg::CNT_W'(gw_pkg::bit_cycles(CLK_HZ, cfg.baud));
    assign tout_cyc = gw_pkg::TOUT_W'(gw_pkg::timeout_ms(cfg.baud, cfg.tout_long) * CYC_PER_MS);

    // ----------------------------------------------------------------
    // output image and transmit sequencing
    // ----------------------------------------------------------------
    typedef enum {TX_IDLE, TX_LOAD, TX_SEND} tx_state_t;
    tx_state_t tx_state, next_tx_state;
    logic [7:0] out_img [gw_pkg::IMG_MAX];
    logic [7:0] next_out_img [gw_pkg::IMG_MAX];
    logic [7:0] toggle_ref, next_toggle_ref;
    logic [7:0] tx_idx, next_tx_idx, tx_end, next_tx_end, tx_byte, next_tx_byte;
    logic tx_start, next_tx_start, conn_q, tx_busy, len_ok;

    assign len_ok = out_img[gw_pkg::IDX_LEN] != 8'h00 && out_img[gw_pkg::IDX_LEN] <= 8'(gw_pkg::FRAME_MAX)
        && 9'(out_img[gw_pkg::IDX_LEN]) + 9'(gw_pkg::HDR_BYTES) <= 9'(out_size);

    always_comb begin
        next_out_img = out_img;
        if (out_wr.wr && out_wr.addr < 8'(gw_pkg::IMG_MAX)) begin
            next_out_img[out_wr.addr] = out_wr.data;
        end
        next_tx_state = tx_state;
        next_toggle_ref = toggle_ref;
        next_tx_idx = tx_idx;
        next_tx_end = tx_end;
        next_tx_byte = tx_byte;
        next_tx_start = 1'b0;
        if (ar_up && !conn_q) begin
            next_toggle_ref = out_img[gw_pkg::IDX_TOGGLE];
        end
        unique case (tx_state)
            TX_IDLE: begin
                if (cfg_valid && ar_up && conn_q && out_img[gw_pkg::IDX_TOGGLE] != toggle_ref) begin
                    next_toggle_ref = out_img[gw_pkg::IDX_TOGGLE];
                    if (len_ok) begin
                        next_tx_idx = gw_pkg::IDX_DATA;
                        next_tx_end = gw_pkg::IDX_DATA + out_img[gw_pkg::IDX_LEN];
                        next_tx_state = TX_LOAD;
                    end
                end
            end
            TX_LOAD: begin
                next_tx_byte = out_img[tx_idx];
                next_tx_start = 1'b1;
                next_tx_idx = tx_idx + 8'h01;
                next_tx_state = TX_SEND;
            end
            TX_SEND: begin
                if (!tx_start && !tx_busy) begin
                    next_tx_state = (tx_idx == tx_end) ? TX_IDLE : TX_LOAD;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < gw_pkg::IMG_MAX; i++) out_img[i] <= 8'h00;
            tx_state <= TX_IDLE;
            toggle_ref <= 8'h00;
            tx_idx <= 8'h00;
            tx_end <= 8'h00;
            tx_byte <= 8'h00;
            tx_start <= 1'b0;
            conn_q <= 1'b0;
        end else begin
            out_img <= next_out_img;
            tx_state <= next_tx_state;
            toggle_ref <= next_toggle_ref;
            tx_idx <= next_tx_idx;
            tx_end <= next_tx_end;
            tx_byte <= next_tx_byte;
            tx_start <= next_tx_start;
            conn_q <= ar_up;
        end
    end

    uart_char_tx u_tx (
        .core_clk(core_clk),
        .nrst(nrst),
        .start(tx_start),
        .data(tx_byte),
        .fmt(cfg.fmt),
        .bit_cyc(bit_cyc),
        .txd(txd),
        .busy(tx_busy)
    );

    // ----------------------------------------------------------------
    // receiver and input image
    // ----------------------------------------------------------------
    typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;
    rx_state_t rx_state, next_rx_state;
    logic [7:0] in_img [gw_pkg::IMG_MAX];
    logic [7:0] next_in_img [gw_pkg::IMG_MAX];
    logic [gw_pkg::CNT_W-1:0] rx_cnt, next_rx_cnt;
    logic [3:0] rx_bit, next_rx_bit;
    logic [8:0] rx_shift, next_rx_shift;
    logic [7:0] rx_count, next_rx_count, rx_limit, rx_byte, next_in_rd_data;
    logic [gw_pkg::TOUT_W-1:0] idle_cnt, next_idle_cnt;
    logic rx_on, rx_ok, tx_active;

    assign tx_active = tx_state != TX_IDLE || tx_busy;
    assign rx_on = cfg_valid && (cfg.four_wire || !tx_active);
    assign rx_limit = (in_size < 8'(gw_pkg::HDR_BYTES)) ? 8'h00 :
        (in_size - 8'(gw_pkg::HDR_BYTES) > 8'(gw_pkg::FRAME_MAX)) ? 8'(gw_pkg::FRAME_MAX) :
        in_size - 8'(gw_pkg::HDR_BYTES);

    always_comb begin
        unique case (cfg.fmt)
            gw_pkg::FMT_8N1: begin
                rx_byte = rx_shift[8:1];
                rx_ok = 1'b1;
            end
            gw_pkg::FMT_8E1: begin
                rx_byte = rx_shift[7:0];
                rx_ok = ~^rx_shift;
            end
            gw_pkg::FMT_8O1: begin
                rx_byte = rx_shift[7:0];
                rx_ok = ^rx_shift;
            end
            gw_pkg::FMT_7N2: begin
                rx_byte = {1'b0, rx_shift[8:2]};
                rx_ok = 1'b1;
            end
        endcase
    end

    always_comb begin
        next_in_img = in_img;
        next_rx_state = rx_state;
        next_rx_cnt = rx_cnt;
        next_rx_bit = rx_bit;
        next_rx_shift = rx_shift;
        next_rx_count = rx_count;
        next_idle_cnt = idle_cnt;
        if (rx_count != 8'h00 && rx_state == RX_IDLE && idle_cnt != tout_cyc) begin
            next_idle_cnt = idle_cnt + 1'b1;
        end
        if (rx_count != 8'h00 && idle_cnt == tout_cyc) begin
            next_in_img[gw_pkg::IDX_LEN] = rx_count;
            next_in_img[gw_pkg::IDX_TOGGLE] = in_img[gw_pkg::IDX_TOGGLE] + 8'h01;
            next_rx_count = 8'h00;
            next_idle_cnt = '0;
        end
        unique case (rx_state)
            RX_IDLE: begin
                if (rx_on && !rxd_f) begin
                    next_rx_cnt = bit_cyc >> 1;
                    next_rx_state = RX_START;
                end
            end
            RX_START: begin
                if (rx_cnt == '0) begin
                    next_rx_cnt = bit_cyc - 1'b1;
                    next_rx_bit = 4'h0;
                    next_rx_state = rxd_f ? RX_IDLE : RX_BITS;
                end else begin
                    next_rx_cnt = rx_cnt - 1'b1;
                end
            end
            RX_BITS: begin
                if (rx_cnt == '0) begin
                    next_rx_shift = {rxd_f, rx_shift[8:1]};
                    next_rx_bit = rx_bit + 4'h1;
                    next_rx_cnt = bit_cyc - 1'b1;
                    if (rx_bit == gw_pkg::rx_bits(cfg.fmt) - 4'h1) next_rx_state = RX_STOP;
                end else begin
                    next_rx_cnt = rx_cnt - 1'b1;
                end
            end
            RX_STOP: begin
                if (rx_cnt == '0) begin
                    next_rx_state = RX_IDLE;
                    if (rxd_f && rx_ok && rx_count < rx_limit) begin
                        next_in_img[gw_pkg::IDX_DATA + rx_count] = rx_byte;
                        next_rx_count = rx_count + 8'h01;
                        next_idle_cnt = '0;
                    end
                end else begin
                    next_rx_cnt = rx_cnt - 1'b1;
                end
            end
        endcase
        if (!rx_on) next_rx_state = RX_IDLE;
        next_in_rd_data = (in_rd_addr < 8'(gw_pkg::IMG_MAX)) ? in_img[in_rd_addr] : 8'h00;
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < gw_pkg::IMG_MAX; i++) in_img[i] <= 8'h00;
            rx_state <= RX_IDLE;
            rx_cnt <= '0;
            rx_bit <= 4'h0;
            rx_shift <= 9'h000;
            rx_count <= 8'h00;
            idle_cnt <= '0;
            in_rd_data <= 8'h00;
        end else begin
            in_img <= next_in_img;
            rx_state <= next_rx_state;
            rx_cnt <= next_rx_cnt;
            rx_bit <= next_rx_bit;
            rx_shift <= next_rx_shift;
            rx_count <= next_rx_count;
            idle_cnt <= next_idle_cnt;
            in_rd_data <= next_in_rd_data;
        end
    end

    // ----------------------------------------------------------------
    // indicators and line drivers
    // ----------------------------------------------------------------
    logic [31:0] blink_cnt, next_blink_cnt;
    logic blink, next_blink;

    always_comb begin
        next_blink_cnt = blink_cnt + 32'h1;
        next_blink = blink;
        if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
            next_blink_cnt = 32'h0;
            next_blink = !blink;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            blink_cnt <= 32'h0;
            blink <= 1'b0;
            run_led <= 1'b0;
            err_led <= 1'b1;
            dev_online <= 1'b0;
            tx_drv_en <= 1'b0;
            rx_en <= 1'b0;
        end else begin
            blink_cnt <= next_blink_cnt;
            blink <= next_blink;
            run_led <= ident_flash ? blink : 1'b1;
            err_led <= !ar_up;
            dev_online <= cfg_valid;
            tx_drv_en <= cfg_valid && (cfg.four_wire || tx_active);
            rx_en <= rx_on;
        end
    end

endmodule : fieldbus_serial_frame_gateway

// >>> design/gw_pkg.sv
// shared constants, types and helpers of the fieldbus serial frame gateway
package gw_pkg;

    // ----------------------------------------------------------------
    // image layout
    // ----------------------------------------------------------------
    localparam int IMG_MAX = 250;
    localparam int FRAME_MAX = 248;
    localparam int HDR_BYTES = 2;
    localparam logic [7:0] IDX_TOGGLE = 8'h00;
    localparam logic [7:0] IDX_LEN = 8'h01;
    localparam logic [7:0] IDX_DATA = 8'h02;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ_DEF = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int BLINK_MS = 250;
    localparam int CNT_W = 17;
    localparam int TOUT_W = 26;
    localparam int STRAP_SETTLE = 3;
    localparam int MIN_BAUD = 1200;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {FMT_8N1, FMT_8E1, FMT_8O1, FMT_7N2} fmt_t;

    typedef struct packed {
        logic [2:0] baud;
        fmt_t fmt;
        logic tout_long;
        logic four_wire;
    } ser_cfg_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } img_wr_t;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic int bit_cycles(input int clk_hz, input logic [2:0] sel);
        case (sel)
            3'h0: return clk_hz / 1200;
            3'h1: return clk_hz / 2400;
            3'h2: return clk_hz / 4800;
            3'h3: return clk_hz / 9600;
            3'h4: return clk_hz / 19200;
            3'h5: return clk_hz / 38400;
            3'h6: return clk_hz / 57600;
            default: return clk_hz / 115200;
        endcase
    endfunction : bit_cycles

    function automatic int timeout_ms(input logic [2:0] sel, input logic long_sel);
        case (sel)
            3'h0: return long_sel ? 200 : 29;
            3'h1: return long_sel ? 100 : 16;
            3'h2: return long_sel ? 50 : 9;
            3'h3: return long_sel ? 25 : 6;
            3'h4: return long_sel ? 13 : 4;
            default: return long_sel ? 10 : 3;
        endcase
    endfunction : timeout_ms

    // serial frame, lsb first: start, data, parity or stop, stop
    function automatic logic [10:0] frame_bits(input logic [7:0] d, input fmt_t f);
        case (f)
            FMT_8N1: return {2'h3, d, 1'b0};
            FMT_8E1: return {1'b1, ^d, d, 1'b0};
            FMT_8O1: return {1'b1, ~^d, d, 1'b0};
            default: return {3'h7, d[6:0], 1'b0};
        endcase
    endfunction : frame_bits

    function automatic logic [3:0] frame_len(input fmt_t f);
        return (f == FMT_8E1 || f == FMT_8O1) ? 4'hb : 4'ha;
    endfunction : frame_len

    // data plus parity bits sampled after the start bit
    function automatic logic [3:0] rx_bits(input fmt_t f);
        case (f)
            FMT_8N1: return 4'h8;
            FMT_7N2: return 4'h7;
            default: return 4'h9;
        endcase
    endfunction : rx_bits

endpackage : gw_pkg

// >>> design/uart_char_tx.sv
// one asynchronous character transmitter
`timescale 1ns/1ns
module uart_char_tx (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [7:0] data,
    input wire gw_pkg::fmt_t fmt,
    input wire logic [gw_pkg::CNT_W-1:0] bit_cyc,
    output logic txd,
    output logic busy
);
    logic [10:0] shreg;
    logic [3:0] bits_left;
    logic [gw_pkg::CNT_W-1:0] cnt;
    logic [10:0] next_shreg;
    logic [3:0] next_bits_left;
    logic [gw_pkg::CNT_W-1:0] next_cnt;
    logic next_txd;
    logic next_busy;
    logic [10:0] fb;

    always_comb begin
        next_shreg = shreg;
        next_bits_left = bits_left;
        next_cnt = cnt;
        next_txd = txd;
        next_busy = busy;
        fb = gw_pkg::frame_bits(data, fmt);
        if (!busy) begin
            next_txd = 1'b1;
            if (start) begin
                next_txd = fb[0];
                next_shreg = fb >> 1;
                next_bits_left = gw_pkg::frame_len(fmt);
                next_cnt = bit_cyc - 1'b1;
                next_busy = 1'b1;
            end
        end else if (cnt == '0) begin
            if (bits_left == 4'h1) begin
                next_busy = 1'b0;
                next_txd = 1'b1;
            end else begin
                next_txd = shreg[0];
                next_shreg = shreg >> 1;
                next_bits_left = bits_left - 4'h1;
                next_cnt = bit_cyc - 1'b1;
            end
        end else begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            shreg <= '1;
            bits_left <= 4'h0;
            cnt <= '0;
            txd <= 1'b1;
            busy <= 1'b0;
        end else begin
            shreg <= next_shreg;
            bits_left <= next_bits_left;
            cnt <= next_cnt;
            txd <= next_txd;
            busy <= next_busy;
        end
    end

endmodule : uart_char_tx

// >>> test/fb_ctrl_model.sv
// cyclic controller model: writes the output image, reads the input image
`timescale 1ns/1ns
module fb_ctrl_model (
    input wire logic core_clk,
    input wire logic [7:0] in_rd_data,
    output gw_pkg::img_wr_t out_wr,
    output logic [7:0] out_size,
    output logic [7:0] in_rd_addr,
    output logic [7:0] in_size,
    output logic ar_up
);
    // images sized at the maximum, two bytes over the longest frame
    assign out_size = 8'hfa;
    assign in_size = 8'hfa;

    initial begin
        out_wr = '0;
        in_rd_addr = 8'h00;
        ar_up = 1'b0;
    end

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        out_wr = '{1'b1, a, d};
        @(negedge core_clk);
        out_wr.wr = 1'b0;
    endtask : put

    // length first, then the toggle byte
    task automatic send(input logic [7:0] len, input logic [7:0] tog);
        put(8'h01, len);
        put(8'h00, tog);
    endtask : send

    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        in_rd_addr = a;
        @(negedge core_clk);
        d = in_rd_data;
    endtask : get

    task automatic link(input logic up);
        @(negedge core_clk);
        ar_up = up;
    endtask : link
endmodule : fb_ctrl_model

// >>> test/fieldbus_serial_frame_gateway_tb_top.sv
// self-checking bench of the fieldbus serial frame gateway
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module fieldbus_serial_frame_gateway_tb_top;
    localparam int BIT = 10;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic ident_flash = 1'b0;
    logic [6:0] dip = 7'h07;
    logic rxd = 1'b1;
    gw_pkg::img_wr_t out_wr;
    logic [7:0] out_size, in_rd_addr, in_rd_data, in_size;
    logic ar_up, txd, tx_drv_en, rx_en, dev_online, run_led, err_led;
    int err_count = 0;
    int total_checks = 0;
    gw_pkg::fmt_t fmt = gw_pkg::FMT_8N1;
    logic [7:0] exp_q[$];

    always #5 core_clk = ~core_clk;

    fieldbus_serial_frame_gateway #(.CLK_HZ(1_152_000), .CYC_PER_MS(10), .BLINK_CYCLES(8))
    i_fieldbus_serial_frame_gateway (
        .core_clk(core_clk), .nrst(nrst), .out_wr(out_wr), .out_size(out_size), .in_rd_addr(in_rd_addr),
        .in_rd_data(in_rd_data), .in_size(in_size), .ar_up(ar_up), .ident_flash(ident_flash), .dip(dip),
        .rxd(rxd), .txd(txd), .tx_drv_en(tx_drv_en), .rx_en(rx_en), .dev_online(dev_online),
        .run_led(run_led), .err_led(err_led)
    );

    fb_ctrl_model i_fb_ctrl_model (
        .core_clk(core_clk), .in_rd_data(in_rd_data), .out_wr(out_wr), .out_size(out_size),
        .in_rd_addr(in_rd_addr), .in_size(in_size), .ar_up(ar_up)
    );

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    task automatic drain;
        int n;
        for (n = 0; n < 60000 && exp_q.size() > 0; n++) tick(1);
        if (n == 60000) begin
            err_count++;
            $display("[ERR] %0t transmit timeout", $time);
            test_done();
        end
        tick(40);
    endtask : drain

    // one character on the receive line in the current format
    task automatic ser_out(input logic [7:0] c);
        rxd = 1'b0;
        tick(BIT);
        for (int i = 0; i < (fmt == gw_pkg::FMT_7N2 ? 7 : 8); i++) begin
            rxd = c[i];
            tick(BIT);
        end
        if (fmt == gw_pkg::FMT_8E1 || fmt == gw_pkg::FMT_8O1) begin
            rxd = (^c) ^ (fmt == gw_pkg::FMT_8O1);
            tick(BIT);
        end
        rxd = 1'b1;
        tick(BIT * 2);
    endtask : ser_out

    // ----------------------------------------------------------------
    // transmit line watcher: decodes characters, checks against notes
    // ----------------------------------------------------------------
    initial begin : tx_watch
        logic [7:0] d;
        logic [7:0] e;
        forever begin
            @(negedge txd);
            if (dev_online === 1'b1) begin
                d = 8'h00;
                repeat (BIT / 2) @(negedge core_clk);
                `CHK(txd, 1'b0)
                for (int i = 0; i < (fmt == gw_pkg::FMT_7N2 ? 7 : 8); i++) begin
                    repeat (BIT) @(negedge core_clk);
                    d[i] = txd;
                end
                if (fmt == gw_pkg::FMT_8E1 || fmt == gw_pkg::FMT_8O1) begin
                    repeat (BIT) @(negedge core_clk);
                    `CHK(txd, (^d) ^ (fmt == gw_pkg::FMT_8O1))
                end
                for (int s = 0; s < (fmt == gw_pkg::FMT_7N2 ? 2 : 1); s++) begin
                    repeat (BIT) @(negedge core_clk);
                    `CHK(txd, 1'b1)
                end
                e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
                `CHK(d, e)
            end
        end
    end

    initial begin : main
        logic [7:0] v;
        logic [7:0] c[3];
        int n;
        void'($urandom(32'hd3a1bd10));
        for (int f = 0; f < 4; f++) begin
            tick(1);
            nrst = 1'b0;
            fmt = gw_pkg::fmt_t'(f);
            dip = {f == 3, 1'b0, fmt, 3'h7};
            tick(6);
            nrst = 1'b1;
            for (n = 0; n < 50 && dev_online !== 1'b1; n++) tick(1);
            `CHK(dev_online, 1'b1)
            if (n == 50) test_done();
            dip[5:0] = 6'($urandom);
            `CHK(err_led, 1'b1)
            // toggle already changed before the link comes up: nothing may go out
            i_fb_ctrl_model.put(8'h02, 8'h55);
            i_fb_ctrl_model.send(8'h01, 8'h05);
            i_fb_ctrl_model.link(1'b1);
            tick(60);
            `CHK(err_led, 1'b0)
            n = (f == 0) ? 248 : 3;
            for (int i = 0; i < n; i++) begin
                v = 8'($urandom);
                i_fb_ctrl_model.put(8'(i + 2), v);
                exp_q.push_back(fmt == gw_pkg::FMT_7N2 ? v & 8'h7f : v);
            end
            i_fb_ctrl_model.send(8'(n), 8'h06);
            tick(40);
            // toggle change mid-frame is taken only after the frame ends
            i_fb_ctrl_model.put(8'h00, 8'h07);
            exp_q = {exp_q, exp_q};
            drain();
            i_fb_ctrl_model.send(8'h00, 8'h08);
            i_fb_ctrl_model.send(8'hf9, 8'h09);
            tick(200);
            for (int i = 0; i < 3; i++) begin
                c[i] = 8'($urandom);
                ser_out(c[i]);
            end
            tick(80);
            i_fb_ctrl_model.get(8'h00, v);
            `CHK(v, 8'h01)
            i_fb_ctrl_model.get(8'h01, v);
            `CHK(v, 8'h03)
            for (int i = 0; i < 3; i++) begin
                i_fb_ctrl_model.get(8'(i + 2), v);
                `CHK(v, fmt == gw_pkg::FMT_7N2 ? c[i] & 8'h7f : c[i])
            end
            i_fb_ctrl_model.get(8'hfa, v);
            `CHK(v, 8'h00)
            ident_flash = 1'b1;
            tick(40);
            ident_flash = 1'b0;
            tick(4);
            `CHK(run_led, 1'b1)
            i_fb_ctrl_model.link(1'b0);
            tick(4);
            `CHK(err_led, 1'b1)
            $display("format %0d done", f);
        end
        test_done();
    end
endmodule : fieldbus_serial_frame_gateway_tb_top

// >>> test/fsfg_properties.sv
// port-level assertions of the fieldbus serial frame gateway
`timescale 1ns/1ns
module fsfg_properties #(
    parameter int BLINK_CYCLES = 8
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire gw_pkg::img_wr_t out_wr,
    input wire logic [7:0] out_size,
    input wire logic [7:0] in_rd_addr,
    input wire logic [7:0] in_rd_data,
    input wire logic [7:0] in_size,
    input wire logic ar_up,
    input wire logic ident_flash,
    input wire logic [6:0] dip,
    input wire logic rxd,
    input wire logic txd,
    input wire logic tx_drv_en,
    input wire logic rx_en,
    input wire logic dev_online,
    input wire logic run_led,
    input wire logic err_led
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------------------------------
    // cycles the run led has stood still while blinking is requested
    // ----------------------------------------------------------------
    int unsigned still;
    int unsigned next_still;
    logic prev_led;
    always_comb begin
        next_still = (ident_flash && run_led == prev_led) ? still + 1 : 0;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            still <= 0;
            prev_led <= 1'b0;
        end else begin
            still <= next_still;
            prev_led <= run_led;
        end
    end

    AST_ERR_OFF: assert property ($rose(ar_up) |=> !err_led)
        else $error("error led still on after link up");
    AST_ERR_ON: assert property (!ar_up ##1 !ar_up |-> err_led)
        else $error("error led off without link");
    AST_RUN_ON: assert property (!ident_flash [*2] |-> run_led)
        else $error("run led off without identify request");
    AST_BLINK: assert property (still <= BLINK_CYCLES + 2)
        else $error("run led not blinking");
    AST_HALF_DUPLEX: assert property (!dip[6] && !txd |-> !rx_en && tx_drv_en)
        else $error("receiver on or driver off while sending in two-wire mode");
    AST_FOUR_WIRE: assert property (dip[6] && $past(dev_online, 2) |-> rx_en && tx_drv_en)
        else $error("receiver or driver off in four-wire mode");
    AST_IDLE_OFFLINE: assert property (!dev_online |-> txd)
        else $error("serial output active before configuration");
    AST_REF_HOLD: assert property ($rose(ar_up) |-> txd [*4])
        else $error("transmission started at connection");
    AST_START_BIT: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit too short");
    AST_ONLINE_KEEP: assert property (dev_online |=> dev_online)
        else $error("ready flag dropped without reset");
    AST_RD_RANGE: assert property (in_rd_addr >= 8'hfa |=> in_rd_data == 8'h00)
        else $error("read beyond image not zero");
endmodule : fsfg_properties

bind fieldbus_serial_frame_gateway fsfg_properties #(.BLINK_CYCLES(BLINK_CYCLES)) i_fsfg_properties (
    .core_clk(core_clk), .nrst(nrst), .out_wr(out_wr), .out_size(out_size), .in_rd_addr(in_rd_addr),
    .in_rd_data(in_rd_data), .in_size(in_size), .ar_up(ar_up), .ident_flash(ident_flash), .dip(dip),
    .rxd(rxd), .txd(txd), .tx_drv_en(tx_drv_en), .rx_en(rx_en), .dev_online(dev_online),
    .run_led(run_led), .err_led(err_led)
);
